// ===== hdl/clock_gen_pkg.sv
package clock_gen_pkg;

  // APB byte address width; the highest register index times four needs 18 bits.
  localparam int APB_AW = 18;

  // Register indices as printed; the byte address is four times the index.
  localparam logic [15:0] IDX_STANDBY_CONTROL     = 16'hff38;
  localparam logic [15:0] IDX_SYSTEM_CLOCK_CTRL   = 16'hff3a;
  localparam logic [15:0] IDX_MODULE_STOP_HIGH    = 16'hff3c;
  localparam logic [15:0] IDX_MODULE_STOP_LOW     = 16'hff3d;
  localparam logic [APB_AW-1:0] ADDR_STANDBY_CONTROL   = {IDX_STANDBY_CONTROL, 2'b00};
  localparam logic [APB_AW-1:0] ADDR_SYSTEM_CLOCK_CTRL = {IDX_SYSTEM_CLOCK_CTRL, 2'b00};
  localparam logic [APB_AW-1:0] ADDR_MODULE_STOP_HIGH  = {IDX_MODULE_STOP_HIGH, 2'b00};
  localparam logic [APB_AW-1:0] ADDR_MODULE_STOP_LOW   = {IDX_MODULE_STOP_LOW, 2'b00};

  // Reset values of the four registers.
  localparam logic [7:0] RST_STANDBY_CONTROL   = 8'h08;
  localparam logic [7:0] RST_SYSTEM_CLOCK_CTRL = 8'h00;
  localparam logic [7:0] RST_MODULE_STOP_HIGH  = 8'h3f;
  localparam logic [7:0] RST_MODULE_STOP_LOW   = 8'hff;

  // Standby control field positions.
  localparam int STANDBY_SELECT_BIT = 7;
  localparam int STANDBY_TIMER_LSB  = 4;
  localparam int OUTPUT_PORT_EN_BIT = 3;
  localparam int STANDBY_RSV0_BIT   = 0;
  // System clock control field positions.
  localparam int CLOCK_OUTPUT_DISABLE_BIT = 7;
  localparam int CLOCK_CTRL_RSV6_BIT      = 6;
  localparam int BUS_MASTER_SEL_LSB       = 0;

  // Bus master clock select codes.
  localparam logic [2:0] SEL_HIGH_SPEED = 3'h0;
  localparam logic [2:0] SEL_LAST_DIV   = 3'h5;
  // Standby timer select code meaning the short wait, and the reserved code.
  localparam logic [2:0] STS_SHORT    = 3'h7;
  localparam logic [2:0] STS_RESERVED = 3'h6;
  localparam int         STANDBY_SHORT_STATES = 16;
  localparam int         STANDBY_BASE_STATES  = 8192;

  // Clock rate and the duty correction threshold.
  localparam int SYS_CLK_MHZ      = 40;
  localparam int DUTY_ADJ_MIN_MHZ = 5;
  localparam bit DUTY_ADJ_NEEDED  = (SYS_CLK_MHZ >= DUTY_ADJ_MIN_MHZ);

  // Number of medium-speed clocks.
  localparam int NUM_MED_CLKS = 5;

  // Operating state of the power controller.
  typedef enum logic [2:0] {
    MODE_RUN,
    MODE_SLEEP,
    MODE_SW_STANDBY,
    MODE_WAKE_WAIT,
    MODE_HW_STANDBY
  } mode_t;

endpackage

// ===== hdl/med_speed_divider.sv
`timescale 1ns/1ps
// Free counter that turns the system clock into one-cycle enables at /2, /4 ... /2**N.
module med_speed_divider #(
  parameter int N = 5
) (
  input  wire logic         i_clk,   // System clock.
  input  wire logic         i_rst_n, // Asynchronous reset, active low.
  input  wire logic         i_run,   // Oscillator running; the counter freezes when low.
  output logic [N-1:0]      o_tick   // One-cycle enables, bit k at rate /2**(k+1).
);

  // All state of the divider.
  typedef struct packed {
    logic [N-1:0] cnt;
    logic [N-1:0] tick;
  } div_state_t;

  div_state_t s_q;  // Registered state.
  div_state_t s_d;  // Next state.

  // A tick fires when the low k+1 bits wrap, so every rate stays phase aligned.
  // A running AND of the low bits avoids a part-select whose bound moves with the loop.
  always_comb begin
    logic ones;
    ones = 1'b1;
    s_d = s_q;
    s_d.tick = '0;
    if (i_run) begin
      s_d.cnt = s_q.cnt + {{(N-1){1'b0}}, 1'b1};
      for (int k = 0; k < N; k++) begin
        ones = ones & s_q.cnt[k];
        s_d.tick[k] = ones;
      end
    end
  end

  // State register.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_tick = s_q.tick;

endmodule

// ===== hdl/clock_gen_power_down_ctrl.sv
`timescale 1ns/1ps
module clock_gen_power_down_ctrl
  import clock_gen_pkg::*;
#(
  parameter int          WAKE_BASE_STATES = STANDBY_BASE_STATES, // Crystal wait in states for timer select code 0.
  parameter int          SERIAL_STOP_BIT  = 5,                   // Module stop bit of the serial interface.
  parameter int          ADC_STOP_BIT     = 9,                   // Module stop bit of the converter.
  parameter logic [15:0] BUS_MASTER_MASK  = 16'hc000             // Module stop bits that are bus masters.
) (
  input  wire logic              I_SYS_CLK,         // System clock, 40 MHz.
  input  wire logic              I_RST_N,           // Asynchronous reset, active low.
  input  wire logic              I_PSEL,            // APB select.
  input  wire logic              I_PENABLE,         // APB access phase.
  input  wire logic              I_PWRITE,          // APB direction, high for write.
  input  wire logic [APB_AW-1:0] I_PADDR,           // APB byte address.
  input  wire logic [31:0]       I_PWDATA,          // APB write data.
  input  wire logic [3:0]        I_PSTRB,           // APB write strobes; lane 0 carries the register.
  output logic                   O_PREADY,          // APB ready.
  output logic [31:0]            O_PRDATA,          // APB read data.
  output logic                   O_PSLVERR,         // APB error for an unmapped address.
  input  wire logic              I_SLEEP_EXEC,      // Pulse: the CPU executed the sleep instruction.
  input  wire logic              I_IRQ,             // Pulse: any interrupt request.
  input  wire logic              I_EXT_IRQ,         // Pulse: external interrupt request.
  input  wire logic              I_BUS_BUSY,        // Level: a bus cycle is in progress.
  input  wire logic              I_HW_STANDBY_N,    // Hardware standby pin, active low.
  output logic                   O_OSC_RUN,         // Oscillator enable.
  output logic                   O_DUTY_ADJ_EN,     // Duty correction stage in the clock path.
  output logic [4:0]             O_MED_CLK_EN,      // Medium-speed enables, /2 to /32.
  output logic                   O_CPU_CLK_EN,      // CPU clock enable.
  output logic                   O_MASTER_CLK_EN,   // Bus master clock enable.
  output logic [15:0]            O_MODULE_CLK_EN,   // Per-module clock enables.
  output logic                   O_SERIAL_RESET,    // Reset to the serial interface.
  output logic                   O_ADC_RESET,       // Reset to the converter.
  output logic                   O_PERIPH_RESET,    // Reset to all peripherals.
  output logic                   O_CPU_REGS_LOST,   // CPU register contents undefined.
  output logic                   O_IO_HIZ,          // All I/O ports float.
  output logic                   O_ADDR_BUS_HIZ,    // Address bus and bus controls float.
  output logic                   O_CLK_OUT,         // System clock output pin level.
  output logic                   O_CLK_OUT_OE       // System clock output pin drive enable.
);

  // All state of the block.
  typedef struct packed {
    mode_t       mode;       // Power state.
    logic        standby_select_bit;       // Standby select bit.
    logic [2:0]  sts;        // Standby timer select.
    logic        ope;        // Output port enable in standby.
    logic        sby_rsv0;   // Read/write reserved bit 0.
    logic        clock_output_disable;      // Clock output disable.
    logic        sck_rsv6;   // Read/write reserved bit 6.
    logic [2:0]  sel;        // Bus master clock select as written.
    logic [2:0]  sel_act;    // Bus master clock select in force.
    logic [15:0] mstp;       // Module stop bits.
    logic [18:0] wake_cnt;   // Oscillator settling countdown.
    logic        phi;        // Level that the clock pin shows.
    logic        cpu_en;
    logic        master_en;
    logic [4:0]  med_en;
    logic [15:0] mod_en;
    logic        osc_run;
    logic        duty_adj;
    logic        ser_rst;
    logic        adc_rst;
    logic        per_rst;
    logic        regs_lost;
    logic        io_hiz;
    logic        addr_hiz;
    logic        clk_oe;
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
  } state_t;

  state_t               s_q;       // Registered state.
  state_t               s_d;       // Next state.
  logic [NUM_MED_CLKS-1:0] med_tick;  // Divider enables.
  logic                 div_run;   // Divider runs while the oscillator does.

  // Picks the enable for a select code; unused codes fall back to full speed.
  function automatic logic sel_enable(input logic [2:0] sel, input logic [NUM_MED_CLKS-1:0] tick);
    logic en;
    en = 1'b1;
    if (sel != SEL_HIGH_SPEED && sel <= SEL_LAST_DIV) begin
      en = tick[sel - 3'h1];
    end
    return en;
  endfunction

  // Number of states to wait for the oscillator after an external wake.
  function automatic logic [18:0] wake_states(input logic [2:0] sts);
    logic [18:0] n;
    n = 19'(WAKE_BASE_STATES);
    if (sts == STS_SHORT) begin
      n = 19'(STANDBY_SHORT_STATES);
    end else if (sts == STS_RESERVED) begin
      n = 19'(WAKE_BASE_STATES) << SEL_LAST_DIV;
    end else begin
      n = 19'(WAKE_BASE_STATES) << sts;
    end
    return n;
  endfunction

  // Rebuilds the power-on register values; used at reset and in hardware standby.
  function automatic state_t reg_defaults(input state_t s);
    state_t r;
    r          = s;
    r.standby_select_bit     = RST_STANDBY_CONTROL[STANDBY_SELECT_BIT];
    r.sts      = RST_STANDBY_CONTROL[STANDBY_TIMER_LSB +: 3];
    r.ope      = RST_STANDBY_CONTROL[OUTPUT_PORT_EN_BIT];
    r.sby_rsv0 = RST_STANDBY_CONTROL[STANDBY_RSV0_BIT];
    r.clock_output_disable    = RST_SYSTEM_CLOCK_CTRL[CLOCK_OUTPUT_DISABLE_BIT];
    r.sck_rsv6 = RST_SYSTEM_CLOCK_CTRL[CLOCK_CTRL_RSV6_BIT];
    r.sel      = RST_SYSTEM_CLOCK_CTRL[BUS_MASTER_SEL_LSB +: 3];
    r.sel_act  = RST_SYSTEM_CLOCK_CTRL[BUS_MASTER_SEL_LSB +: 3];
    r.mstp     = {RST_MODULE_STOP_HIGH, RST_MODULE_STOP_LOW};
    return r;
  endfunction

  // Reset image of the whole state; the CPU and master enables begin high, module and medium enables low.
  function automatic state_t state_reset();
    state_t r;
    r          = '0;
    r          = reg_defaults(r);
    r.mode     = MODE_RUN;
    r.cpu_en   = 1'b1;
    r.master_en = 1'b1;
    r.osc_run  = 1'b1;
    r.duty_adj = DUTY_ADJ_NEEDED;
    r.clk_oe   = 1'b1;
    r.ser_rst  = 1'b1;
    r.adc_rst  = 1'b1;
    r.per_rst  = 1'b1;
    return r;
  endfunction

  assign div_run = s_q.osc_run;

  med_speed_divider #(
    .N(NUM_MED_CLKS)
  ) u_divider (
    .i_clk  (I_SYS_CLK),
    .i_rst_n(I_RST_N),
    .i_run  (div_run),
    .o_tick (med_tick)
  );

  // Next-state logic: bus slave, mode sequencing and registered outputs.
  always_comb begin
    logic        acc_setup;
    logic        acc_write;
    logic        mapped;
    logic [7:0]  rd_byte;
    logic        halted;
    logic        standby;
    logic        bus_clk;
    acc_setup = I_PSEL && !I_PENABLE;
    acc_write = I_PSEL && I_PENABLE && s_q.pready && I_PWRITE && I_PSTRB[0];
    mapped    = 1'b1;
    rd_byte   = 8'h00;
    halted    = 1'b0;
    standby   = 1'b0;
    bus_clk   = 1'b0;
    s_d       = s_q;

    // Ready rises in the cycle after setup, so every access has exactly one wait-free access cycle.
    s_d.pready  = acc_setup;
    s_d.pslverr = 1'b0;
    if (acc_setup) begin
      // Reserved bits 5 to 3 of clock control and 2 to 1 of standby control read as zero.
      case (I_PADDR)
        ADDR_STANDBY_CONTROL:   rd_byte = {s_q.standby_select_bit, s_q.sts, s_q.ope, 2'b00, s_q.sby_rsv0};
        ADDR_SYSTEM_CLOCK_CTRL: rd_byte = {s_q.clock_output_disable, s_q.sck_rsv6, 3'b000, s_q.sel};
        ADDR_MODULE_STOP_HIGH:  rd_byte = s_q.mstp[15:8];
        ADDR_MODULE_STOP_LOW:   rd_byte = s_q.mstp[7:0];
        default:                mapped = 1'b0;
      endcase
      s_d.prdata  = {24'h000000, rd_byte};
      s_d.pslverr = !mapped;
    end

    if (acc_write) begin
      case (I_PADDR)
        ADDR_STANDBY_CONTROL: begin
          s_d.standby_select_bit     = I_PWDATA[STANDBY_SELECT_BIT];
          s_d.sts      = I_PWDATA[STANDBY_TIMER_LSB +: 3];
          s_d.ope      = I_PWDATA[OUTPUT_PORT_EN_BIT];
          s_d.sby_rsv0 = I_PWDATA[STANDBY_RSV0_BIT];
        end
        ADDR_SYSTEM_CLOCK_CTRL: begin
          s_d.clock_output_disable    = I_PWDATA[CLOCK_OUTPUT_DISABLE_BIT];
          s_d.sck_rsv6 = I_PWDATA[CLOCK_CTRL_RSV6_BIT];
          s_d.sel      = I_PWDATA[BUS_MASTER_SEL_LSB +: 3];
        end
        ADDR_MODULE_STOP_HIGH: s_d.mstp[15:8] = I_PWDATA[7:0];
        ADDR_MODULE_STOP_LOW:  s_d.mstp[7:0]  = I_PWDATA[7:0];
        default: begin
          // Unmapped writes change nothing; the error flag reports them.
        end
      endcase
    end

    // switch after bus cycle
    // The written select takes hold only in a cycle with no bus cycle open, so no access is cut in two.
    if (!I_BUS_BUSY) begin
      s_d.sel_act = s_q.sel;
    end

    // Power state sequencing.
    case (s_q.mode)
      MODE_RUN: begin
        if (I_SLEEP_EXEC) begin
          s_d.mode = s_q.standby_select_bit ? MODE_SW_STANDBY : MODE_SLEEP;
        end
      end
      MODE_SLEEP: begin
        // Any interrupt wakes the CPU from sleep.
        if (I_IRQ || I_EXT_IRQ) begin
          s_d.mode = MODE_RUN;
        end
      end
      MODE_SW_STANDBY: begin
        // only external interrupt
        // The select bit stays set after the wake; software clears it itself.
        if (I_EXT_IRQ) begin
          s_d.mode     = MODE_WAKE_WAIT;
          s_d.wake_cnt = wake_states(s_q.sts);
        end
      end
      MODE_WAKE_WAIT: begin
        // The oscillator runs again but nothing is clocked until it has settled.
        if (s_q.wake_cnt <= 19'h00001) begin
          s_d.mode     = MODE_RUN;
          s_d.wake_cnt = '0;
        end else begin
          s_d.wake_cnt = s_q.wake_cnt - 19'h00001;
        end
      end
      MODE_HW_STANDBY: begin
        // Leaving the pin state restarts in high-speed mode like a reset.
        if (I_HW_STANDBY_N) begin
          s_d.mode = MODE_RUN;
        end
      end
      default: s_d.mode = MODE_RUN;
    endcase

    // hardware standby pin
    // The pin wins over everything and brings the registers back to their reset values.
    if (!I_HW_STANDBY_N) begin
      s_d      = reg_defaults(s_d);
      s_d.mode = MODE_HW_STANDBY;
    end

    standby = (s_d.mode == MODE_SW_STANDBY) || (s_d.mode == MODE_HW_STANDBY);
    halted  = standby || (s_d.mode == MODE_WAKE_WAIT);
    s_d.osc_run = !standby;

    s_d.duty_adj = DUTY_ADJ_NEEDED && !standby;

    s_d.med_en = halted ? '0 : med_tick;

    bus_clk = !halted && sel_enable(s_q.sel_act, med_tick);

    // high speed after reset
    // With the reset select of zero the masters and CPU see every system clock edge.
    s_d.master_en = bus_clk;

    s_d.cpu_en = bus_clk && (s_d.mode == MODE_RUN);

    // per-module stop
    // Other bus masters follow the medium clock; plain peripherals stay at full speed.
    for (int i = 0; i < 16; i++) begin
      s_d.mod_en[i] = !halted && !s_d.mstp[i] && (BUS_MASTER_MASK[i] ? bus_clk : 1'b1);
    end

    // reset serial and converter
    // Held for as long as the module is stopped or the chip is in standby.
    s_d.ser_rst = s_d.mstp[SERIAL_STOP_BIT] || standby;
    s_d.adc_rst = s_d.mstp[ADC_STOP_BIT] || standby;
    s_d.per_rst = (s_d.mode == MODE_HW_STANDBY);

    s_d.regs_lost = (s_d.mode == MODE_HW_STANDBY);
    s_d.io_hiz    = (s_d.mode == MODE_HW_STANDBY);
    // In software standby the address bus floats unless the port enable bit keeps it driven.
    s_d.addr_hiz  = (s_d.mode == MODE_HW_STANDBY) || ((s_d.mode == MODE_SW_STANDBY) && !s_d.ope);

    // external clock held high
    // The pin is forced high across standby, matching what an inverted external drive must hold.
    // clock pin control
    // The pin copy toggles at half rate because one clock domain cannot emit its own waveform.
    if (standby || s_d.clock_output_disable) begin
      s_d.phi = 1'b1;
    end else begin
      s_d.phi = !s_q.phi;
    end
    s_d.clk_oe = (s_d.mode != MODE_HW_STANDBY);
  end

  // State register.
  always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      s_q <= state_reset();
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs come straight from the state register.
  assign O_PREADY        = s_q.pready;
  assign O_PRDATA        = s_q.prdata;
  assign O_PSLVERR       = s_q.pslverr;
  assign O_OSC_RUN       = s_q.osc_run;
  assign O_DUTY_ADJ_EN   = s_q.duty_adj;
  assign O_MED_CLK_EN    = s_q.med_en;
  assign O_CPU_CLK_EN    = s_q.cpu_en;
  assign O_MASTER_CLK_EN = s_q.master_en;
  assign O_MODULE_CLK_EN = s_q.mod_en;
  assign O_SERIAL_RESET  = s_q.ser_rst;
  assign O_ADC_RESET     = s_q.adc_rst;
  assign O_PERIPH_RESET  = s_q.per_rst;
  assign O_CPU_REGS_LOST = s_q.regs_lost;
  assign O_IO_HIZ        = s_q.io_hiz;
  assign O_ADDR_BUS_HIZ  = s_q.addr_hiz;
  assign O_CLK_OUT       = s_q.phi;
  assign O_CLK_OUT_OE    = s_q.clk_oe;

endmodule

// ===== dv/cpu_side_model.sv
`timescale 1ns/1ps
// Stand-in for the CPU and bus masters; every request leaves just after a clock edge.
module cpu_side_model (
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  input  wire logic i_sleep_req,
  input  wire logic i_irq_req,
  input  wire logic i_ext_req,
  input  wire logic i_busy_req,
  input  wire logic i_osc_run,
  output logic      o_sleep_exec,
  output logic      o_irq,
  output logic      o_ext_irq,
  output logic      o_bus_busy,
  output logic      o_ext_clk
);
  // Requests are registered, so each one holds for a full cycle and never glitches.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      {o_sleep_exec, o_irq, o_ext_irq, o_bus_busy} <= 4'h0;
      o_ext_clk <= 1'b1;
    end else begin
      {o_sleep_exec, o_irq, o_ext_irq, o_bus_busy} <= {i_sleep_req, i_irq_req, i_ext_req, i_busy_req};
      o_ext_clk <= i_osc_run ? !o_ext_clk : 1'b1;
    end
  end
endmodule

// ===== dv/clock_gen_chk.sv
`timescale 1ns/1ps
// Port-level checks on the clock and power-down controller.
module clock_gen_chk (
  input wire logic       I_SYS_CLK,
  input wire logic       I_RST_N,
  input wire logic       I_PSEL,
  input wire logic       I_PENABLE,
  input wire logic       I_HW_STANDBY_N,
  input wire logic       O_PREADY,
  input wire logic       O_PSLVERR,
  input wire logic       O_OSC_RUN,
  input wire logic       O_DUTY_ADJ_EN,
  input wire logic [4:0] O_MED_CLK_EN,
  input wire logic       O_CPU_CLK_EN,
  input wire logic       O_MASTER_CLK_EN,
  input wire logic       O_SERIAL_RESET,
  input wire logic       O_ADC_RESET,
  input wire logic       O_PERIPH_RESET,
  input wire logic       O_CPU_REGS_LOST,
  input wire logic       O_IO_HIZ,
  input wire logic       O_CLK_OUT,
  input wire logic       O_CLK_OUT_OE
);
  // One clock domain, so clocking and disable are declared once.
  default clocking cb @(posedge I_SYS_CLK); endclocking
  default disable iff (!I_RST_N);

  duty_adj_a: assert property (O_OSC_RUN |-> O_DUTY_ADJ_EN)
    else $error("Duty stage off while the oscillator runs.");
  half_rate_a: assert property (O_MED_CLK_EN[0] |=> !O_MED_CLK_EN[0])
    else $error("Half-rate enable too dense.");
  eighth_rate_a: assert property (O_MED_CLK_EN[2] |=> !O_MED_CLK_EN[2] [*7])
    else $error("Eighth-rate enable too dense.");
  reset_speed_a: assert property ($rose(I_RST_N) |-> O_CPU_CLK_EN && O_MASTER_CLK_EN)
    else $error("Not at full speed after reset.");
  osc_halt_a: assert property (!O_OSC_RUN |-> !O_CPU_CLK_EN && O_MED_CLK_EN == 5'h00)
    else $error("Clocks run with the oscillator halted.");
  standby_reset_a: assert property (!O_OSC_RUN && O_CLK_OUT_OE |-> O_SERIAL_RESET && O_ADC_RESET)
    else $error("Serial or converter not reset in standby.");
  standby_pin_a: assert property (!O_OSC_RUN && O_CLK_OUT_OE |-> O_CLK_OUT)
    else $error("Clock pin not high in software standby.");
  hw_entry_a: assert property (!I_HW_STANDBY_N [*2] |=> !O_CLK_OUT_OE && O_IO_HIZ && O_PERIPH_RESET
    && O_CPU_REGS_LOST && !O_OSC_RUN) else $error("Hardware standby not entered.");
  apb_ready_a: assert property (I_PSEL && !I_PENABLE |=> O_PREADY ##1 !O_PREADY)
    else $error("Ready not a single cycle after setup.");
  slverr_ready_a: assert property (O_PSLVERR |-> O_PREADY)
    else $error("Error response without ready.");

  // Main scenarios seen at least once.
  cover property (!O_OSC_RUN && O_CLK_OUT_OE);
  cover property (!O_CLK_OUT_OE);
  cover property (O_OSC_RUN && O_CPU_CLK_EN ##1 !O_CPU_CLK_EN ##1 O_CPU_CLK_EN);
  cover property (O_PSLVERR);
endmodule

bind clock_gen_power_down_ctrl clock_gen_chk u_chk (
  .I_SYS_CLK(I_SYS_CLK), .I_RST_N(I_RST_N), .I_PSEL(I_PSEL), .I_PENABLE(I_PENABLE),
  .I_HW_STANDBY_N(I_HW_STANDBY_N), .O_PREADY(O_PREADY), .O_PSLVERR(O_PSLVERR),
  .O_OSC_RUN(O_OSC_RUN), .O_DUTY_ADJ_EN(O_DUTY_ADJ_EN), .O_MED_CLK_EN(O_MED_CLK_EN),
  .O_CPU_CLK_EN(O_CPU_CLK_EN), .O_MASTER_CLK_EN(O_MASTER_CLK_EN), .O_SERIAL_RESET(O_SERIAL_RESET),
  .O_ADC_RESET(O_ADC_RESET), .O_PERIPH_RESET(O_PERIPH_RESET), .O_CPU_REGS_LOST(O_CPU_REGS_LOST),
  .O_IO_HIZ(O_IO_HIZ), .O_CLK_OUT(O_CLK_OUT), .O_CLK_OUT_OE(O_CLK_OUT_OE));

// ===== dv/clock_gen_power_down_ctrl_tb.sv
`timescale 1ns/1ps
// Self-checking bench: APB master, CPU stand-in and enable-pulse counters.
module clock_gen_power_down_ctrl_tb import clock_gen_pkg::*;;
  logic clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0, hw_n = 1;
  logic sl_q = 0, irq_q = 0, ext_q = 0, busy_q = 0;
  logic [APB_AW-1:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata;
  logic pready, pslverr, slp, irq, ext, busy, osc, duty, cpu, mst, srst, arst, prst, lost, hiz, abz, cko, coe, eclk;
  logic [4:0] med;
  logic [15:0] mods;
  int n_errors = 0, checks = 0, cyc = 0, ncpu, nmst, nm0, nm15, nck;
  int nmed[5];
  // Register map and the bits that keep a written value.
  logic [APB_AW-1:0] adr[4] = '{ADDR_STANDBY_CONTROL, ADDR_SYSTEM_CLOCK_CTRL, ADDR_MODULE_STOP_HIGH, ADDR_MODULE_STOP_LOW};
  logic [7:0] msk[4] = '{8'hf9, 8'hc7, 8'hff, 8'hff};

  initial forever #12.5 clk = ~clk;

  clock_gen_power_down_ctrl #(.WAKE_BASE_STATES(4)) DUT (.I_SYS_CLK(clk), .I_RST_N(rst_n), .I_PSEL(psel),
    .I_PENABLE(pen), .I_PWRITE(pwr), .I_PADDR(paddr), .I_PWDATA(pwdata), .I_PSTRB(4'h1), .O_PREADY(pready),
    .O_PRDATA(prdata), .O_PSLVERR(pslverr), .I_SLEEP_EXEC(slp), .I_IRQ(irq), .I_EXT_IRQ(ext),
    .I_BUS_BUSY(busy), .I_HW_STANDBY_N(hw_n), .O_OSC_RUN(osc), .O_DUTY_ADJ_EN(duty), .O_MED_CLK_EN(med),
    .O_CPU_CLK_EN(cpu), .O_MASTER_CLK_EN(mst), .O_MODULE_CLK_EN(mods), .O_SERIAL_RESET(srst),
    .O_ADC_RESET(arst), .O_PERIPH_RESET(prst), .O_CPU_REGS_LOST(lost), .O_IO_HIZ(hiz),
    .O_ADDR_BUS_HIZ(abz), .O_CLK_OUT(cko), .O_CLK_OUT_OE(coe));

  cpu_side_model u_cpu (.i_clk(clk), .i_rst_n(rst_n), .i_sleep_req(sl_q), .i_irq_req(irq_q), .i_ext_req(ext_q),
    .i_busy_req(busy_q), .i_osc_run(osc), .o_sleep_exec(slp), .o_irq(irq), .o_ext_irq(ext),
    .o_bus_busy(busy), .o_ext_clk(eclk));

  task automatic finish_test;
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // One APB transfer; the request holds until ready is seen high at a rising edge.
  // Read data and error are taken at that same edge; only the global timeout ends a hang.
  task automatic apb(input logic wr, input logic [APB_AW-1:0] a, input logic [7:0] d,
                     output logic [7:0] r, output logic e);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= wr;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    r = prdata[7:0];
    e = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask

  task automatic wr(input logic [APB_AW-1:0] a, input logic [7:0] d);
    logic [7:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rdc(input string nm, input logic [APB_AW-1:0] a, input logic [7:0] x);
    logic [7:0] r;
    logic e;
    apb(1'b0, a, 8'h00, r, e);
    chk(nm, {24'h000000, x}, {24'h000000, r});
  endtask

  // Counts enable pulses over n settled cycles.
  task automatic cnt(input int n);
    {ncpu, nmst, nm0, nm15, nck} = '0;
    nmed = '{default: 0};
    repeat (n) begin
      @(negedge clk);
      ncpu += (cpu === 1'b1);
      nmst += (mst === 1'b1);
      nm0 += (mods[0] === 1'b1);
      nm15 += (mods[15] === 1'b1);
      nck += (cko === 1'b1);
      for (int k = 0; k < 5; k++) nmed[k] += (med[k] === 1'b1);
    end
  endtask

  // Bit 2 sleep, bit 1 any interrupt, bit 0 external interrupt.
  task automatic pulse(input int s);
    @(posedge clk);
    {sl_q, irq_q, ext_q} <= 3'(1 << s);
    @(posedge clk);
    {sl_q, irq_q, ext_q} <= 3'b000;
    repeat (3) @(posedge clk);
  endtask

  // Pulses of the bus master clock in 64 cycles for a select code.
  function automatic int exp_cnt(input logic [2:0] c);
    return (c == SEL_HIGH_SPEED || c > SEL_LAST_DIV) ? 64 : 64 >> c;
  endfunction

  // A hang counts as a mismatch.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc > 6000) begin
      n_errors++;
      finish_test;
    end
  end

  initial begin
    logic [7:0] r, v;
    logic e;
    void'($urandom(18461));
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 4; i++) rdc("reset value", adr[i], i == 0 ? 8'h08 : i == 1 ? 8'h00 : i == 2 ? 8'h3f : 8'hff);
    apb(1'b0, 18'h00010, 8'h00, r, e);
    chk("unmapped", 32'h1, {31'h0, e});
    chk("duty", 32'h1, {31'h0, duty});
    for (int i = 0; i < 12; i++) begin
      v = 8'($urandom);
      wr(adr[i % 4], v);
      rdc("readback", adr[i % 4], v & msk[i % 4]);
    end
    wr(ADDR_STANDBY_CONTROL, 8'h08);
    wr(ADDR_SYSTEM_CLOCK_CTRL, 8'h00);
    wr(ADDR_MODULE_STOP_LOW, 8'h20);
    wr(ADDR_MODULE_STOP_HIGH, 8'h02);
    repeat (2) @(negedge clk);
    chk("module enables", 32'h0000fddf, {16'h0, mods});
    chk("stop resets", 32'h3, {30'h0, srst, arst});
    wr(ADDR_MODULE_STOP_LOW, 8'h00);
    wr(ADDR_MODULE_STOP_HIGH, 8'h00);
    repeat (2) @(negedge clk);
    chk("run resets", 32'h0, {30'h0, srst, arst});
    for (int c = 0; c < 8; c++) begin
      busy_q <= 1'b1;
      wr(ADDR_SYSTEM_CLOCK_CTRL, 8'(c));
      cnt(6);
      if (c == 1) chk("busy hold", 32'd6, ncpu);
      @(posedge clk);
      busy_q <= 1'b0;
      repeat (8) @(posedge clk);
      cnt(64);
      chk("cpu rate", exp_cnt(3'(c)), ncpu);
      chk("master rate", exp_cnt(3'(c)), nmst);
      chk("master module", exp_cnt(3'(c)), nm15);
      chk("periph rate", 32'd64, nm0);
    end
    for (int k = 0; k < 5; k++) chk("divider", 32'(64 >> (k + 1)), nmed[k]);
    wr(ADDR_SYSTEM_CLOCK_CTRL, 8'h02);
    wr(ADDR_MODULE_STOP_LOW, 8'h08);
    pulse(2);
    cnt(16);
    chk("sleep cpu", 32'd0, ncpu);
    chk("sleep periph", 32'd16, nm0);
    chk("sleep stop", 32'h2, {30'h0, osc, mods[3]});
    pulse(1);
    cnt(64);
    chk("wake rate", 32'd16, ncpu);
    wr(ADDR_SYSTEM_CLOCK_CTRL, 8'h00);
    wr(ADDR_STANDBY_CONTROL, 8'h80);
    pulse(2);
    pulse(1);
    @(negedge clk);
    chk("standby", 32'h0f, {27'h0, osc, cko, abz, srst, arst});
    chk("ext clock parked", 32'h1, {31'h0, eclk});
    pulse(0);
    repeat (24) @(posedge clk);
    @(negedge clk);
    chk("standby wake", 32'h3, {30'h0, osc, cpu});
    rdc("select kept", ADDR_STANDBY_CONTROL, 8'h80);
    wr(ADDR_SYSTEM_CLOCK_CTRL, 8'h80);
    repeat (2) @(posedge clk);
    cnt(8);
    chk("pin held", 32'd8, nck);
    wr(ADDR_SYSTEM_CLOCK_CTRL, 8'h05);
    repeat (2) @(posedge clk);
    cnt(8);
    chk("pin toggles", 32'd4, nck);
    @(posedge clk);
    hw_n <= 1'b0;
    repeat (4) @(posedge clk);
    @(negedge clk);
    chk("hw standby", 32'h7, {28'h0, coe, prst, lost, hiz});
    @(posedge clk);
    hw_n <= 1'b1;
    repeat (4) @(posedge clk);
    rdc("hw clock reg", ADDR_SYSTEM_CLOCK_CTRL, RST_SYSTEM_CLOCK_CTRL);
    rdc("hw standby reg", ADDR_STANDBY_CONTROL, RST_STANDBY_CONTROL);
    cnt(8);
    chk("hw exit speed", 32'd8, ncpu);
    finish_test;
  end
endmodule
